/* bench/tb.sv */
// Self-checking bench for the temperature rate unit with a behavioural reference.
`timescale 1ns/100ps
`default_nettype none

module tb;
	import trcu_pkg::*;

	logic core_clk;
	logic reset_n;
	logic diode_two_antiparallel;
	trcu_reg_req_type reg_req;
	logic conv_done;
	logic [7:0] t1;
	logic [7:0] t2;
	logic [7:0] t3;
	logic [7:0] reg_rdata_ff;
	logic rate_alert_ff;
	int error_cnt = 0;
	int check_count = 0;
	int it, k, c, j, src, gc, sc, n, lim, ap, mask;
	int tp[3][5];
	int r[2];
	int hit[2];
	int mx[2];
	int wt[5] = '{25, 35, 30, 45, 35};
	logic [7:0] ws[5] = '{8'h00, 8'h00, 8'hF0, 8'hC0, 8'hFC};
	logic [7:0] a;

	trcu_host u_host (.core_clk(core_clk), .rdata(reg_rdata_ff), .req(reg_req),
		.conv_done(conv_done), .t_one(t1), .t_two(t2), .t_three(t3));

	trcu_top u_dut (.core_clk(core_clk), .reset_n(reset_n), .reg_req(reg_req),
		.conv_done(conv_done), .temp_diode_one(t1), .temp_diode_two(t2),
		.temp_diode_three(t3), .diode_two_antiparallel(diode_two_antiparallel),
		.reg_rdata_ff(reg_rdata_ff), .rate_alert_ff(rate_alert_ff));

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	task automatic conclude();
		if (error_cnt == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic rchk(input logic [7:0] ad, input logic [7:0] e, input logic [7:0] m);
		logic [7:0] d;
		u_host.rd(ad, d);
		chk($sformatf("reg %h", ad), e, d & m);
	endtask

	// Fixed point with three fraction bits; inputs keep the result non-negative and unsaturated.
	function automatic int rate_fix(int first, int last, int gcode, int cnt);
		int g;
		g = gcode[3] ? (1 << gcode[2:0]) : 1;
		return ((last - first) * g * 8) / (cnt - 1);
	endfunction

	initial begin
		#(25 * 6000);
		error_cnt++;
		conclude();
	end

	initial begin
		reset_n = 1'b0;
		diode_two_antiparallel = 1'b0;
		void'($urandom(34414));
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		reset_n = 1'b1;
		for (a = 8'h3D; a <= 8'h4F; a++) rchk(a, RST_REG, 8'hFF);
		u_host.wr(OFS_RESULT_ONE_HIGH, 8'h55);
		u_host.wr(8'h4C, 8'hAA);
		rchk(OFS_RESULT_ONE_HIGH, 8'h00, 8'hFF);
		rchk(8'h4C, 8'h00, 8'hFF);
		u_host.wr(OFS_RATE_GAIN, 8'h09);
		u_host.wr(OFS_SAMPLES_ONE, 8'h02);
		u_host.wr(OFS_SAMPLES_TWO, 8'h02);
		u_host.wr(OFS_LIMIT_ONE_HIGH, 8'h01);
		u_host.wr(OFS_LIMIT_TWO_HIGH, 8'h01);
		rchk(OFS_RATE_GAIN, 8'h09, 8'hFF);
		u_host.wr(OFS_RATE_CONFIG, 8'h20);
		for (k = 0; k < 5; k++) begin
			u_host.conv(8'(wt[k]), 8'(wt[k]), 8'(wt[k]));
			if (k == 4) chk("alert", 8'h01, {7'h00, rate_alert_ff});
			rchk(OFS_RATE_STATUS, ws[k], 8'hFF);
		end
		// The alert register follows the cleared status one edge after the read.
		@(negedge core_clk);
		chk("alert after read", 8'h00, {7'h00, rate_alert_ff});
		rchk(OFS_RESULT_ONE_HIGH, 8'h02, 8'hFF);
		rchk(OFS_RESULT_TWO_HIGH, 8'h02, 8'hFF);
		rchk(OFS_RESULT_LOW_SHARED, 8'h88, 8'hFF);
		rchk(OFS_PERIOD_MAX_ONE, 8'h2D, 8'hFF);
		rchk(OFS_GLOBAL_MAX_ONE, 8'h2D, 8'hFF);
		rchk(OFS_GLOBAL_MAX_ONE, 8'h00, 8'hFF);
		rchk(OFS_GLOBAL_MAX_TWO, 8'h2D, 8'hFF);
		rchk(OFS_SLOPE_COUNT, 8'h33, 8'hFF);
		for (k = 0; k < 4; k++) u_host.conv(8'd39, 8'd39, 8'd39);
		rchk(OFS_RESULT_ONE_HIGH, 8'h01, 8'hFF);
		rchk(OFS_RATE_STATUS, 8'h00, 8'h0C);
		// These reads also clear the global maxima before the random periods.
		rchk(OFS_GLOBAL_MAX_ONE, 8'h27, 8'hFF);
		rchk(OFS_GLOBAL_MAX_TWO, 8'h27, 8'hFF);
		for (it = 0; it < 14; it++) begin
			gc = ($urandom % 2) ? 8 + $urandom % 4 : 0;
			sc = $urandom % 3;
			n = (1 << sc) + 1;
			lim = $urandom % 21;
			ap = $urandom % 2;
			mask = $urandom % 2;
			u_host.wr(OFS_RATE_CONFIG, 8'h00);
			u_host.conv(8'hFF, 8'hFF, 8'hFF);
			u_host.wr(OFS_RATE_GAIN, 8'(gc));
			u_host.wr(OFS_SAMPLES_ONE, 8'(sc));
			u_host.wr(OFS_SAMPLES_TWO, 8'(sc));
			u_host.wr(OFS_LIMIT_ONE_HIGH, 8'(lim >> 1));
			u_host.wr(OFS_LIMIT_TWO_HIGH, 8'(lim >> 1));
			u_host.wr(OFS_LIMIT_ONE_LOW, 8'((lim & 1) << 7));
			u_host.wr(OFS_LIMIT_TWO_LOW, 8'((lim & 1) << 7));
			diode_two_antiparallel = ap[0];
			u_host.wr(OFS_RATE_CONFIG, mask ? 8'hA0 : 8'h20);
			for (k = 0; k < n; k++) begin
				for (c = 0; c < 3; c++) begin
					tp[c][k] = (k == 0) ? 20 + $urandom % 60 :
						(k == n - 1) ? tp[c][0] + $urandom % 32 : 10 + $urandom % 100;
				end
				u_host.conv(8'(tp[0][k]), 8'(tp[1][k]), 8'(tp[2][k]));
			end
			for (j = 0; j < 2; j++) begin
				src = (j == 0) ? 0 : (ap ? 2 : 1);
				r[j] = rate_fix(tp[src][0], tp[src][n - 1], gc, n);
				hit[j] = ((r[j] >> 3) > lim) ? 1 : 0;
				mx[j] = 0;
				for (k = 0; k < n; k++) mx[j] = (tp[src][k] > mx[j]) ? tp[src][k] : mx[j];
			end
			chk("alert", 8'(!mask && (hit[0] || hit[1])), {7'h00, rate_alert_ff});
			rchk(OFS_RESULT_ONE_HIGH, 8'(r[0] >> 4), 8'hFF);
			rchk(OFS_RESULT_TWO_HIGH, 8'(r[1] >> 4), 8'hFF);
			rchk(OFS_RESULT_LOW_SHARED, 8'(((r[1] & 15) << 4) | (r[0] & 15)), 8'hFF);
			rchk(OFS_RATE_STATUS, 8'((hit[1] << 3) | (hit[0] << 2)), 8'h0C);
			rchk(OFS_PERIOD_MAX_ONE, 8'(mx[0]), 8'hFF);
			rchk(OFS_PERIOD_MAX_TWO, 8'(mx[1]), 8'hFF);
			rchk(OFS_GLOBAL_MAX_ONE, 8'(mx[0]), 8'hFF);
			rchk(OFS_GLOBAL_MAX_TWO, 8'(mx[1]), 8'hFF);
		end
		conclude();
	end
endmodule

`default_nettype wire

/* bench/trcu_host.sv */
// Host-side model: register requests and conversion pulses toward the rate unit.
`timescale 1ns/100ps
`default_nettype none

module trcu_host (
	input wire logic core_clk,
	input wire logic [7:0] rdata,
	output var trcu_pkg::trcu_reg_req_type req,
	output logic conv_done,
	output logic [7:0] t_one,
	output logic [7:0] t_two,
	output logic [7:0] t_three
);
	import trcu_pkg::*;

	initial begin
		req = '0;
		conv_done = 1'b0;
		t_one = 8'h00;
		t_two = 8'h00;
		t_three = 8'h00;
	end

	// Every request changes on a falling edge, so the rising edge sees settled values.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(negedge core_clk);
		req.wr = 1'b0;
		req.wdata = ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge core_clk);
		req.addr = a;
		req.rd = 1'b1;
		@(negedge core_clk);
		req.rd = 1'b0;
		d = rdata;
	endtask

	// One conversion advances the unit by one sample; temperatures are only valid with the pulse.
	task automatic conv(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
		@(negedge core_clk);
		t_one = a;
		t_two = b;
		t_three = c;
		conv_done = 1'b1;
		@(negedge core_clk);
		conv_done = 1'b0;
		t_one = ~a;
		t_two = ~b;
		t_three = ~c;
		repeat (2) @(negedge core_clk);
	endtask
endmodule

`default_nettype wire

/* hw/trcu_pkg.sv */
// Package of offsets, field positions and carrier types for the temperature rate unit.
package trcu_pkg;
	localparam logic [7:0] OFS_RATE_GAIN = 8'h3D;
	localparam logic [7:0] OFS_RATE_CONFIG = 8'h3E;
	localparam logic [7:0] OFS_RATE_STATUS = 8'h3F;
	localparam logic [7:0] OFS_RESULT_ONE_HIGH = 8'h40;
	localparam logic [7:0] OFS_LIMIT_ONE_HIGH = 8'h41;
	localparam logic [7:0] OFS_LIMIT_ONE_LOW = 8'h42;
	localparam logic [7:0] OFS_SAMPLES_ONE = 8'h43;
	localparam logic [7:0] OFS_RESULT_TWO_HIGH = 8'h44;
	localparam logic [7:0] OFS_RESULT_LOW_SHARED = 8'h45;
	localparam logic [7:0] OFS_LIMIT_TWO_HIGH = 8'h46;
	localparam logic [7:0] OFS_LIMIT_TWO_LOW = 8'h47;
	localparam logic [7:0] OFS_SAMPLES_TWO = 8'h48;
	localparam logic [7:0] OFS_PERIOD_MAX_ONE = 8'h49;
	localparam logic [7:0] OFS_PERIOD_MAX_TWO = 8'h4A;
	localparam logic [7:0] OFS_SLOPE_COUNT = 8'h4B;
	localparam logic [7:0] OFS_GLOBAL_MAX_ONE = 8'h4D;
	localparam logic [7:0] OFS_GLOBAL_MAX_TWO = 8'h4F;

	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [11:0] RST_RESULT = 12'h000;

	localparam int CFG_MASK_BIT = 7;
	localparam int CFG_ENABLE_BIT = 5;
	localparam int GAIN_SCALE_BIT = 3;
	localparam int LIMIT_LOW_BIT = 7;
	localparam int STAT_SLOPE_TWO = 7;
	localparam int STAT_SLOPE_ONE = 6;
	localparam int STAT_ODD_TWO = 5;
	localparam int STAT_ODD_ONE = 4;
	localparam int STAT_LIMIT_TWO = 3;
	localparam int STAT_LIMIT_ONE = 2;
	localparam int FRAC_BITS = 3;

	typedef struct packed {
		logic enable;
		logic [3:0] hyst;
		logic [2:0] gain_shift;
		logic [2:0] samp_code;
		logic signed [8:0] limit;
	} trcu_chan_cfg_type;

	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} trcu_reg_req_type;
endpackage

/* hw/trcu_top.sv */
// Temperature rate-of-change unit: per-channel slope calculator and its register file.
// Contract
// [RULE1] Period result is (last minus first) times gain over samples minus one.
// [RULE2] Two channels; second follows diode three when diode two is anti-parallel.
// [RULE3] Gain comes from the gain register; code 09h gives gain two.
// [RULE4] Period length equals programmed samples; code 02h selects five samples.
// [RULE5] Limit code 01h means two; limits signed across two consecutive registers.
// [RULE6] Config value 20h enables the function with zero slope hysteresis.
// [RULE7] Flag slope change when consecutive differences reverse beyond hysteresis.
// [RULE8] Initial slope of a period comes from its first two samples.
// [RULE9] After the final conversion, compute, load result and compare with limit.
// [RULE10] Result above limit sets that channel's bits in the status register.
// [RULE11] Alert asserts only with mask clear; status updates regardless.
// [RULE12] Result is 9-bit signed; low bits shared, channel two bit 7, one bit 3.
// [RULE13] Period maximum holds highest temperature of period, updated each conversion.
// [RULE14] Global maximum updated at each period end, independent of period.
// [RULE15] Global extreme register clears when software reads it.
// [RULE16] Software advances one sample in standby by a one-shot conversion.
// [RULE17] Software places the device in standby before configuring.
// [RULE18] After a period the counter restarts; last sample starts the next period.
// [RULE19] Slope-change count and parity reported, cleared at each period start.
`timescale 1ns/100ps
`default_nettype none

module trcu_channel (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire trcu_pkg::trcu_chan_cfg_type cfg,
	input wire logic conv_pulse,
	input wire logic [7:0] temp_in,
	input wire logic gmax_clear,
	output logic [11:0] result_ff,
	output logic limit_hit_ff,
	output logic slope_chg_ff,
	output logic odd_ff,
	output logic [3:0] count_ff,
	output logic [7:0] pmax_ff,
	output logic [7:0] gmax_ff
);
	import trcu_pkg::*;

	logic started_ff;
	logic [7:0] cnt_ff;
	logic [7:0] t0_ff;
	logic [7:0] prev_ff;
	logic dir_valid_ff;
	logic dir_up_ff;

	logic step;
	logic [7:0] samp_n;
	logic [7:0] nxt_cnt;
	logic period_end;
	logic second_sample;
	logic signed [8:0] step_diff;
	logic [8:0] step_abs;
	logic step_up;
	logic step_big;
	logic slope_event;
	logic signed [8:0] span_diff;
	logic signed [19:0] scaled;
	logic signed [19:0] divided;
	logic [11:0] sat;
	logic [7:0] pmax_in;

	assign step = conv_pulse && cfg.enable && started_ff;
	// Sample count is 2^code + 1, so dividing by samples minus one is a right shift.
	assign samp_n = (8'h01 << cfg.samp_code) + 8'h01;
	assign nxt_cnt = cnt_ff + 8'h01;
	assign period_end = step && (nxt_cnt >= samp_n); // [RULE4]
	assign second_sample = (cnt_ff == 8'h01);
	assign step_diff = $signed({1'b0, temp_in}) - $signed({1'b0, prev_ff});
	assign step_abs = step_diff[8] ? 9'(-step_diff) : 9'(step_diff);
	assign step_up = !step_diff[8];
	assign step_big = (step_abs > {5'h00, cfg.hyst}); // [RULE7]
	assign slope_event = step && !second_sample && dir_valid_ff && step_big
		&& (step_up != dir_up_ff); // [RULE7]
	assign span_diff = $signed({1'b0, temp_in}) - $signed({1'b0, t0_ff});
	// Three fraction bits are kept below the integer result before the divide.
	// The shift amount is summed at four bits; three bits would wrap for the larger gains.
	assign scaled = 20'(span_diff) <<< (4'(cfg.gain_shift) + 4'(FRAC_BITS)); // [RULE1]
	assign divided = scaled >>> cfg.samp_code; // [RULE1]
	assign pmax_in = (temp_in > pmax_ff) ? temp_in : pmax_ff;

	always_comb begin
		if (divided > 20'sd2047) begin
			sat = 12'h7FF;
		end else if (divided < -20'sd2048) begin
			sat = 12'h800;
		end else begin
			sat = divided[11:0];
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			started_ff <= 1'b0;
			cnt_ff <= RST_REG;
			t0_ff <= RST_REG;
			prev_ff <= RST_REG;
		end else if (!cfg.enable) begin
			started_ff <= 1'b0;
			cnt_ff <= RST_REG;
		end else if (conv_pulse && !started_ff) begin
			started_ff <= 1'b1;
			cnt_ff <= 8'h01;
			t0_ff <= temp_in;
			prev_ff <= temp_in;
		end else if (period_end) begin
			cnt_ff <= 8'h01; // [RULE18]
			t0_ff <= temp_in; // [RULE18]
			prev_ff <= temp_in;
		end else if (step) begin
			cnt_ff <= nxt_cnt;
			prev_ff <= temp_in;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			dir_valid_ff <= 1'b0;
			dir_up_ff <= 1'b0;
		end else if (!started_ff) begin
			dir_valid_ff <= 1'b0;
		end else if (step && second_sample) begin
			dir_valid_ff <= (step_diff != 9'sd0); // [RULE8]
			dir_up_ff <= step_up; // [RULE8]
		end else if (step && !dir_valid_ff && step_big) begin
			dir_valid_ff <= 1'b1;
			dir_up_ff <= step_up;
		end else if (slope_event) begin
			dir_up_ff <= step_up;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			slope_chg_ff <= 1'b0;
			odd_ff <= 1'b0;
			count_ff <= 4'h0;
		end else if (step && second_sample) begin
			slope_chg_ff <= 1'b0; // [RULE19]
			odd_ff <= 1'b0;
			count_ff <= 4'h0;
		end else if (slope_event) begin
			slope_chg_ff <= 1'b1; // [RULE7]
			odd_ff <= !odd_ff; // [RULE19]
			count_ff <= (count_ff == 4'hF) ? count_ff : count_ff + 4'h1;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			result_ff <= RST_RESULT;
			limit_hit_ff <= 1'b0;
		end else begin
			limit_hit_ff <= period_end && ($signed(sat[11:3]) > cfg.limit); // [RULE9]
			if (period_end) begin
				result_ff <= sat; // [RULE9]
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pmax_ff <= RST_REG;
		end else if (conv_pulse && cfg.enable && !started_ff) begin
			pmax_ff <= temp_in;
		end else if (step && second_sample) begin
			pmax_ff <= (temp_in > t0_ff) ? temp_in : t0_ff; // [RULE13]
		end else if (step) begin
			pmax_ff <= pmax_in; // [RULE13]
		end
	end

	// The update at period end outranks a clearing read in the same cycle.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			gmax_ff <= RST_REG;
		end else if (period_end) begin
			gmax_ff <= (pmax_in > gmax_ff) ? pmax_in : gmax_ff; // [RULE14]
		end else if (gmax_clear) begin
			gmax_ff <= RST_REG; // [RULE15]
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	a_period_count: assert property (started_ff |-> cnt_ff < samp_n || !cfg.enable) // [RULE4]
		else $error("sample counter ran past the period length");
	a_restart_carry: assert property (period_end |=> cnt_ff == 8'h01 && t0_ff == $past(temp_in)) // [RULE18]
		else $error("period did not restart from its last sample");
	a_result_hold: assert property (!period_end |=> $stable(result_ff)) // [RULE1]
		else $error("result changed outside a period end");
	a_limit_compare: assert property (period_end && cfg.limit == $signed(9'h000)
		&& !sat[11] && sat[11:3] != 9'h000 |=> limit_hit_ff) // [RULE10]
		else $error("positive result over zero limit not flagged");
	a_slope_reset: assert property (step && second_sample |=> count_ff == 4'h0 && !odd_ff) // [RULE19]
		else $error("slope count not cleared at period start");
	a_pmax_cover: assert property (step && !second_sample |=> pmax_ff >= $past(temp_in)) // [RULE13]
		else $error("period maximum below latest sample");
	a_gmax_track: assert property (period_end |=> gmax_ff >= $past(pmax_ff)) // [RULE14]
		else $error("global maximum below period maximum");
	a_slope_parity: assert property (slope_event && !odd_ff |=> odd_ff && slope_chg_ff) // [RULE7]
		else $error("slope change not recorded");
	a_gmax_clear: assert property (gmax_clear && !period_end |=> gmax_ff == RST_REG) // [RULE15]
		else $error("global maximum not cleared by read");
endmodule

module trcu_top (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire trcu_pkg::trcu_reg_req_type reg_req,
	input wire logic conv_done,
	input wire logic [7:0] temp_diode_one,
	input wire logic [7:0] temp_diode_two,
	input wire logic [7:0] temp_diode_three,
	input wire logic diode_two_antiparallel,
	output logic [7:0] reg_rdata_ff,
	output logic rate_alert_ff
);
	import trcu_pkg::*;

	logic [7:0] gain_ff;
	logic [7:0] config_ff;
	logic [7:0] lim1_hi_ff;
	logic [7:0] lim1_lo_ff;
	logic [7:0] samp1_ff;
	logic [7:0] lim2_hi_ff;
	logic [7:0] lim2_lo_ff;
	logic [7:0] samp2_ff;
	logic [1:0] limit_stat_ff;
	logic [1:0] ap_sync_ff;

	trcu_chan_cfg_type cfg1;
	trcu_chan_cfg_type cfg2;
	logic [2:0] gain_shift;
	logic [7:0] temp_two_sel;
	logic [7:0] rd_mux;
	logic rd_status;
	logic [1:0] gmax_clr;
	logic [11:0] res1;
	logic [11:0] res2;
	logic [1:0] hit;
	logic [1:0] slope_chg;
	logic [1:0] odd;
	logic [3:0] cnt1;
	logic [3:0] cnt2;
	logic [7:0] pmax1;
	logic [7:0] pmax2;
	logic [7:0] gmax1;
	logic [7:0] gmax2;

	// Codes with the scale bit set double per step; 09h yields a gain of two.
	assign gain_shift = gain_ff[GAIN_SCALE_BIT] ? gain_ff[2:0] : 3'h0; // [RULE3]
	assign temp_two_sel = ap_sync_ff[1] ? temp_diode_three : temp_diode_two; // [RULE2]
	assign cfg1 = '{enable: config_ff[CFG_ENABLE_BIT], hyst: config_ff[3:0], // [RULE6]
		gain_shift: gain_shift, samp_code: samp1_ff[2:0],
		limit: $signed({lim1_hi_ff, lim1_lo_ff[LIMIT_LOW_BIT]})}; // [RULE5]
	assign cfg2 = '{enable: config_ff[CFG_ENABLE_BIT], hyst: config_ff[3:0],
		gain_shift: gain_shift, samp_code: samp2_ff[2:0],
		limit: $signed({lim2_hi_ff, lim2_lo_ff[LIMIT_LOW_BIT]})}; // [RULE5]
	assign rd_status = reg_req.rd && (reg_req.addr == OFS_RATE_STATUS);
	assign gmax_clr[0] = reg_req.rd && (reg_req.addr == OFS_GLOBAL_MAX_ONE);
	assign gmax_clr[1] = reg_req.rd && (reg_req.addr == OFS_GLOBAL_MAX_TWO);

	// The wiring strap is a pin, so it passes two flip-flops before it steers channel two.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ap_sync_ff <= 2'b00;
		end else begin
			ap_sync_ff <= {ap_sync_ff[0], diode_two_antiparallel};
		end
	end

	trcu_channel u_chan_one (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.cfg(cfg1),
		.conv_pulse(conv_done),
		.temp_in(temp_diode_one),
		.gmax_clear(gmax_clr[0]),
		.result_ff(res1),
		.limit_hit_ff(hit[0]),
		.slope_chg_ff(slope_chg[0]),
		.odd_ff(odd[0]),
		.count_ff(cnt1),
		.pmax_ff(pmax1),
		.gmax_ff(gmax1)
	);

	trcu_channel u_chan_two (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.cfg(cfg2),
		.conv_pulse(conv_done),
		.temp_in(temp_two_sel),
		.gmax_clear(gmax_clr[1]),
		.result_ff(res2),
		.limit_hit_ff(hit[1]),
		.slope_chg_ff(slope_chg[1]),
		.odd_ff(odd[1]),
		.count_ff(cnt2),
		.pmax_ff(pmax2),
		.gmax_ff(gmax2)
	);

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			gain_ff <= RST_REG;
			config_ff <= RST_REG;
			lim1_hi_ff <= RST_REG;
			lim1_lo_ff <= RST_REG;
			samp1_ff <= RST_REG;
			lim2_hi_ff <= RST_REG;
			lim2_lo_ff <= RST_REG;
			samp2_ff <= RST_REG;
		end else if (reg_req.wr) begin
			if (reg_req.addr == OFS_RATE_GAIN) begin
				gain_ff <= reg_req.wdata; // [RULE3]
			end else if (reg_req.addr == OFS_RATE_CONFIG) begin
				config_ff <= reg_req.wdata; // [RULE6]
			end else if (reg_req.addr == OFS_LIMIT_ONE_HIGH) begin
				lim1_hi_ff <= reg_req.wdata;
			end else if (reg_req.addr == OFS_LIMIT_ONE_LOW) begin
				lim1_lo_ff <= reg_req.wdata & 8'h80;
			end else if (reg_req.addr == OFS_SAMPLES_ONE) begin
				samp1_ff <= reg_req.wdata & 8'h07; // [RULE4]
			end else if (reg_req.addr == OFS_LIMIT_TWO_HIGH) begin
				lim2_hi_ff <= reg_req.wdata;
			end else if (reg_req.addr == OFS_LIMIT_TWO_LOW) begin
				lim2_lo_ff <= reg_req.wdata & 8'h80;
			end else if (reg_req.addr == OFS_SAMPLES_TWO) begin
				samp2_ff <= reg_req.wdata & 8'h07;
			end
		end
	end

	// Limit flags are sticky until the status read; a new hit in that cycle survives.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			limit_stat_ff <= 2'b00;
		end else begin
			limit_stat_ff <= (rd_status ? 2'b00 : limit_stat_ff) | hit; // [RULE10]
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rate_alert_ff <= 1'b0;
		end else begin
			rate_alert_ff <= (|limit_stat_ff) && !config_ff[CFG_MASK_BIT]; // [RULE11]
		end
	end

	always_comb begin
		rd_mux = RST_REG;
		if (reg_req.addr == OFS_RATE_GAIN) begin
			rd_mux = gain_ff;
		end else if (reg_req.addr == OFS_RATE_CONFIG) begin
			rd_mux = config_ff;
		end else if (reg_req.addr == OFS_RATE_STATUS) begin
			rd_mux[STAT_SLOPE_TWO] = slope_chg[1];
			rd_mux[STAT_SLOPE_ONE] = slope_chg[0];
			rd_mux[STAT_ODD_TWO] = odd[1]; // [RULE19]
			rd_mux[STAT_ODD_ONE] = odd[0];
			rd_mux[STAT_LIMIT_TWO] = limit_stat_ff[1];
			rd_mux[STAT_LIMIT_ONE] = limit_stat_ff[0];
		end else if (reg_req.addr == OFS_RESULT_ONE_HIGH) begin
			rd_mux = res1[11:4]; // [RULE12]
		end else if (reg_req.addr == OFS_LIMIT_ONE_HIGH) begin
			rd_mux = lim1_hi_ff;
		end else if (reg_req.addr == OFS_LIMIT_ONE_LOW) begin
			rd_mux = lim1_lo_ff;
		end else if (reg_req.addr == OFS_SAMPLES_ONE) begin
			rd_mux = samp1_ff;
		end else if (reg_req.addr == OFS_RESULT_TWO_HIGH) begin
			rd_mux = res2[11:4];
		end else if (reg_req.addr == OFS_RESULT_LOW_SHARED) begin
			rd_mux = {res2[3:0], res1[3:0]}; // [RULE12]
		end else if (reg_req.addr == OFS_LIMIT_TWO_HIGH) begin
			rd_mux = lim2_hi_ff;
		end else if (reg_req.addr == OFS_LIMIT_TWO_LOW) begin
			rd_mux = lim2_lo_ff;
		end else if (reg_req.addr == OFS_SAMPLES_TWO) begin
			rd_mux = samp2_ff;
		end else if (reg_req.addr == OFS_PERIOD_MAX_ONE) begin
			rd_mux = pmax1;
		end else if (reg_req.addr == OFS_PERIOD_MAX_TWO) begin
			rd_mux = pmax2;
		end else if (reg_req.addr == OFS_SLOPE_COUNT) begin
			rd_mux = {cnt2, cnt1}; // [RULE19]
		end else if (reg_req.addr == OFS_GLOBAL_MAX_ONE) begin
			rd_mux = gmax1;
		end else if (reg_req.addr == OFS_GLOBAL_MAX_TWO) begin
			rd_mux = gmax2;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata_ff <= RST_REG;
		end else if (reg_req.rd) begin
			reg_rdata_ff <= rd_mux;
		end
	end

	a_alert_masked: assert property (@(posedge core_clk) disable iff (!reset_n)
		config_ff[CFG_MASK_BIT] |=> !rate_alert_ff) // [RULE11]
		else $error("alert raised while masked");
	a_status_set: assert property (@(posedge core_clk) disable iff (!reset_n)
		hit[0] |=> limit_stat_ff[0] ##1 (limit_stat_ff[0] || $past(rd_status))) // [RULE10]
		else $error("limit hit not held in status");
endmodule

`default_nettype wire
